// ===== pkg/unemt_pkg.sv
// Shared constants and types for the node event and mask tree.
package unemt_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] OFF_MAIN_EVENT = 8'h00;
   localparam logic [7:0] OFF_MAIN_MASK = 8'h04;
   localparam logic [7:0] OFF_BUS_EVENTS = 8'h08;
   localparam logic [7:0] OFF_BUS_MASK = 8'h0c;
   localparam logic [7:0] OFF_TX_EVENTS = 8'h10;
   localparam logic [7:0] OFF_TX_MASK = 8'h14;
   localparam logic [7:0] OFF_RX_EVENTS = 8'h18;
   localparam logic [7:0] OFF_RX_MASK = 8'h1c;
   localparam logic [7:0] OFF_NODE_STATE = 8'h20;
   // Main event and main mask bit positions.
   localparam int MAIN_WARN_BIT = 0;
   localparam int MAIN_ALT_BIT = 1;
   localparam int MAIN_TX_BIT = 2;
   localparam int MAIN_LOCK_BIT = 5;
   localparam int MAIN_RX_BIT = 6;
   localparam int MAIN_ENABLE_BIT = 7;
   // Bus condition event bit positions.
   localparam int BUS_EOP_BIT = 3;
   localparam int BUS_SD3_BIT = 4;
   localparam int BUS_SD5_BIT = 5;
   localparam int BUS_RESET_BIT = 6;
   localparam int BUS_RESUME_BIT = 7;
   localparam logic [7:0] BUS_IMPL_MASK = 8'hf8;
   // Reset values and the suspended node state.
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] EVENTS_RESET = 8'h00;
   localparam logic [1:0] NODE_STATE_RESET = 2'h0;
   localparam logic [1:0] NODE_SUSPENDED = 2'h3;
   // Timing at a 4 ns clock period.
   localparam int CLK_PERIOD_PS = 4000;
   localparam int SD3_TIME_MS = 3;
   localparam int SD5_TIME_MS = 5;
   localparam int SE0_TIME_PS = 2500000;
   localparam int SD3_CYCLES = SD3_TIME_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int SD5_CYCLES = SD5_TIME_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int SE0_CYCLES = (SE0_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int IDLE_CNT_W = 21;
   localparam int SE0_CNT_W = 10;

   // Status from the serial engine and endpoint controllers, same clock.
   typedef struct packed {
      logic frame_unlocked_status;
      logic line_idle;
      logic line_se0;
      logic resume_seen;
      logic eop_seen;
      logic [3:0] tx_done_set;
      logic [3:0] tx_underflow_set;
      logic [3:0] tx_status_read;
      logic [3:0] rx_last_set;
      logic [3:0] rx_err_set;
      logic [3:0] rx_overflow_set;
      logic [3:0] rx_status_read;
   } unemt_sie_t;
endpackage

// ===== hw/unemt_event_tree.sv
// Event and mask hierarchy with interrupt output and APB register slave.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - Frame lock state change sets the lock-change flag; main event read clears it.
// - Receive summary follows unmasked receive events; clears when those sources clear.
// - Main event bit 7 reads zero; main mask bit 7 is the master enable.
// - A main event interrupts only with its mask bit one; masks reset zero.
// - 3 ms continuous idle sets short suspend flag; firmware then writes suspend.
// - 5 ms idle sets long suspend flag; bus condition read clears it.
// - SE0 held 2.5 us sets bus-reset flag; read clears it.
// - Resume signalling while node state is 11 sets the resume flag.
// - Valid end of packet sets the packet-end flag; read clears it.
// - Bus condition mask bits gate events into the bus condition summary.
// - Transmit complete bits set on IN done, clear on status read.
// - Upper transmit bits flag underflow, clear on transmit status read.
// - Endpoint 0 underflow bit always reads zero.
// - Transmit mask gates transmit events into transmit summary; resets zero.
// - Receive complete bits set on receive last or error, clear on status read.
// - Endpoint 0 receive bit reflects receive last only, never error.
// - Receive overflow bits set on overrun, clear on receive event read.
// - Receive mask gates receive events into receive summary; resets zero.
// - Bus condition summary set by unmasked event, cleared on that register read.
// - Transmit summary set by unmasked transmit event, clears when sources clear.
module unemt_event_tree #(
   parameter int SD3_COUNT = unemt_pkg::SD3_CYCLES,
   parameter int SD5_COUNT = unemt_pkg::SD5_CYCLES
) (
   // Clock, reset and freeze.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial engine and endpoint status.
   input wire unemt_pkg::unemt_sie_t sie,
   // Node state and interrupt.
   output logic [1:0] node_state_field,
   output logic irq
);

   logic [7:0] main_interrupt_mask_q;
   logic [7:0] bus_condition_events_q;
   logic [7:0] bus_condition_mask_q;
   logic [7:0] transmit_events_q;
   logic [7:0] transmit_event_mask_q;
   logic [7:0] receive_events_q;
   logic [7:0] receive_event_mask_q;
   logic [1:0] node_state_reg_q;
   logic lock_change_flag_q;
   logic bus_condition_summary_q;
   logic unlocked_prev_q;
   logic [unemt_pkg::IDLE_CNT_W-1:0] idle_cnt_q;
   logic [unemt_pkg::SE0_CNT_W-1:0] se0_cnt_q;
   logic [7:0] prdata_d;
   logic [31:0] prdata_q;
   logic [7:0] main_event_reg;
   logic [7:0] bus_set;
   logic transmit_summary;
   logic receive_summary;
   logic access;
   logic wr;
   logic rd;
   logic mapped;
   logic sd3_hit;
   logic sd5_hit;
   logic se0_hit;

   // Sticky bit update where a new event wins over a clear in the same cycle.
   function automatic logic [7:0] sticky(input logic [7:0] q, input logic [7:0] set,
                                         input logic [7:0] clr);
      sticky = set | (q & ~clr);
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // The freeze input also stalls the bus, but a read set up while frozen returns the previously captured data.
   assign pready = clk_en;
   assign access = psel & penable & clk_en;
   assign wr = access & pwrite;
   assign rd = access & ~pwrite;
   assign prdata = prdata_q;

   always_comb begin
      mapped = 1'b1;
      if (hit(paddr, unemt_pkg::OFF_MAIN_EVENT)) begin
         prdata_d = main_event_reg;
      end else if (hit(paddr, unemt_pkg::OFF_MAIN_MASK)) begin
         prdata_d = main_interrupt_mask_q;
      end else if (hit(paddr, unemt_pkg::OFF_BUS_EVENTS)) begin
         prdata_d = bus_condition_events_q;
      end else if (hit(paddr, unemt_pkg::OFF_BUS_MASK)) begin
         prdata_d = bus_condition_mask_q;
      end else if (hit(paddr, unemt_pkg::OFF_TX_EVENTS)) begin
         prdata_d = transmit_events_q;
      end else if (hit(paddr, unemt_pkg::OFF_TX_MASK)) begin
         prdata_d = transmit_event_mask_q;
      end else if (hit(paddr, unemt_pkg::OFF_RX_EVENTS)) begin
         prdata_d = receive_events_q;
      end else if (hit(paddr, unemt_pkg::OFF_RX_MASK)) begin
         prdata_d = receive_event_mask_q;
      end else if (hit(paddr, unemt_pkg::OFF_NODE_STATE)) begin
         prdata_d = {6'h00, node_state_reg_q};
      end else begin
         prdata_d = 8'h00;
         mapped = 1'b0;
      end
   end

   // Unmapped addresses complete with an error and read zero.
   assign pslverr = psel & penable & ~mapped;

   // Read data is captured in the setup cycle so it is stable when pready samples.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (clk_en && psel && !penable) begin
         prdata_q <= {24'h00_0000, prdata_d};
      end
   end

   // Software mask and node state registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_interrupt_mask_q <= unemt_pkg::MASK_RESET;
         bus_condition_mask_q <= unemt_pkg::MASK_RESET;
         transmit_event_mask_q <= unemt_pkg::MASK_RESET;
         receive_event_mask_q <= unemt_pkg::MASK_RESET;
         node_state_reg_q <= unemt_pkg::NODE_STATE_RESET;
      end else if (wr) begin
         if (hit(paddr, unemt_pkg::OFF_MAIN_MASK)) begin
            main_interrupt_mask_q <= pwdata[7:0];
         end
         if (hit(paddr, unemt_pkg::OFF_BUS_MASK)) begin
            bus_condition_mask_q <= pwdata[7:0] & unemt_pkg::BUS_IMPL_MASK;
         end
         if (hit(paddr, unemt_pkg::OFF_TX_MASK)) begin
            transmit_event_mask_q <= pwdata[7:0];
         end
         if (hit(paddr, unemt_pkg::OFF_RX_MASK)) begin
            receive_event_mask_q <= pwdata[7:0];
         end
         if (hit(paddr, unemt_pkg::OFF_NODE_STATE)) begin
            node_state_reg_q <= pwdata[1:0];
         end
      end
   end

   assign node_state_field = node_state_reg_q;

   // Upstream idle timer; it saturates so each flag fires once per idle period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_q <= '0;
      end else if (clk_en) begin
         if (!sie.line_idle) begin
            idle_cnt_q <= '0;
         end else if (idle_cnt_q < SD5_COUNT[unemt_pkg::IDLE_CNT_W-1:0]) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
         end
      end
   end

   assign sd3_hit = sie.line_idle &&
                    (idle_cnt_q == SD3_COUNT[unemt_pkg::IDLE_CNT_W-1:0] - 1'b1);
   assign sd5_hit = sie.line_idle &&
                    (idle_cnt_q == SD5_COUNT[unemt_pkg::IDLE_CNT_W-1:0] - 1'b1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         se0_cnt_q <= '0;
      end else if (clk_en) begin
         if (!sie.line_se0) begin
            se0_cnt_q <= '0;
         end else if (se0_cnt_q < unemt_pkg::SE0_CYCLES[unemt_pkg::SE0_CNT_W-1:0]) begin
            se0_cnt_q <= se0_cnt_q + 1'b1;
         end
      end
   end

   assign se0_hit = sie.line_se0 &&
                    (se0_cnt_q == unemt_pkg::SE0_CYCLES[unemt_pkg::SE0_CNT_W-1:0] - 1'b1);

   always_comb begin
      bus_set = 8'h00;
      bus_set[unemt_pkg::BUS_SD3_BIT] = sd3_hit;
      bus_set[unemt_pkg::BUS_SD5_BIT] = sd5_hit;
      bus_set[unemt_pkg::BUS_RESET_BIT] = se0_hit;
      bus_set[unemt_pkg::BUS_RESUME_BIT] = sie.resume_seen &&
                                           (node_state_reg_q == unemt_pkg::NODE_SUSPENDED);
      bus_set[unemt_pkg::BUS_EOP_BIT] = sie.eop_seen;
   end

   // Bus condition events, all cleared by reading the register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_condition_events_q <= unemt_pkg::EVENTS_RESET;
      end else if (clk_en) begin
         bus_condition_events_q <= sticky(bus_condition_events_q, bus_set,
            {8{rd && hit(paddr, unemt_pkg::OFF_BUS_EVENTS)}});
      end
   end

   // Summary latches on the incoming unmasked event, so a clear never hides a new one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_condition_summary_q <= 1'b0;
      end else if (clk_en) begin
         bus_condition_summary_q <= (|(bus_set & bus_condition_mask_q)) |
            (|(bus_condition_events_q & bus_condition_mask_q) & !bus_condition_summary_q &
             !(rd && hit(paddr, unemt_pkg::OFF_BUS_EVENTS))) |
            (bus_condition_summary_q &
             !(rd && hit(paddr, unemt_pkg::OFF_BUS_EVENTS)));
      end
   end

   // Transmit events follow endpoint status; reading this register leaves them alone.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transmit_events_q <= unemt_pkg::EVENTS_RESET;
      end else if (clk_en) begin
         // Endpoint 0 cannot underflow, so its set input is tied low and bit 4 stays zero.
         transmit_events_q <= sticky(transmit_events_q,
            {sie.tx_underflow_set[3:1], 1'b0, sie.tx_done_set},
            {sie.tx_status_read, sie.tx_status_read});
      end
   end

   // Receive events: complete bits clear on status read, overflow bits on this read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         receive_events_q <= unemt_pkg::EVENTS_RESET;
      end else if (clk_en) begin
         receive_events_q <= sticky(receive_events_q,
            {sie.rx_overflow_set, sie.rx_last_set | {sie.rx_err_set[3:1], 1'b0}},
            {{4{rd && hit(paddr, unemt_pkg::OFF_RX_EVENTS)}}, sie.rx_status_read});
      end
   end

   // Frame timer lock state change detection.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlocked_prev_q <= 1'b1;
         lock_change_flag_q <= 1'b0;
      end else if (clk_en) begin
         unlocked_prev_q <= sie.frame_unlocked_status;
         lock_change_flag_q <= (sie.frame_unlocked_status != unlocked_prev_q) |
            (lock_change_flag_q & !(rd && hit(paddr, unemt_pkg::OFF_MAIN_EVENT)));
      end
   end

   // Level summaries drop only once every contributing source bit is cleared.
   assign transmit_summary = |(transmit_events_q & transmit_event_mask_q);
   assign receive_summary = |(receive_events_q & receive_event_mask_q);

   always_comb begin
      main_event_reg = 8'h00;
      main_event_reg[unemt_pkg::MAIN_ALT_BIT] = bus_condition_summary_q;
      main_event_reg[unemt_pkg::MAIN_TX_BIT] = transmit_summary;
      main_event_reg[unemt_pkg::MAIN_LOCK_BIT] = lock_change_flag_q;
      main_event_reg[unemt_pkg::MAIN_RX_BIT] = receive_summary;
   end

   // The interrupt is a register so it is glitch free toward the microcontroller.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= main_interrupt_mask_q[unemt_pkg::MAIN_ENABLE_BIT] &&
                (|(main_event_reg[6:0] & main_interrupt_mask_q[6:0]));
      end
   end

endmodule

// ===== verif/unemt_event_tree_props.sv
// Concurrent checks on the ports of the node event and mask tree.
`timescale 1ns/1ps
module unemt_event_tree_props #(
   parameter int SD3_COUNT = 30,
   parameter int SD5_COUNT = 50
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Status and outputs.
   input wire unemt_pkg::unemt_sie_t sie,
   input wire logic [1:0] node_state_field,
   input wire logic irq
);
   logic [7:0] msk_q [4];
   logic msk_sel;
   assign msk_sel = psel && penable && paddr[2] && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
   // A shadow of the four masks lets irq be tied back to the gates that allow it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msk_q <= '{default: 8'h00};
      end else if (msk_sel && pwrite && clk_en) begin
         msk_q[paddr[4:3]] <= pwdata[7:0] & (paddr[4:3] == 2'h1 ? 8'hf8 : 8'hff);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [7:0] off);
      psel && penable && !pwrite && paddr == off;
   endsequence
   sequence s_arm(int b);
      clk_en && msk_q[0][7] && msk_q[0][b];
   endsequence
   a_master_gate: assert property (clk_en && !msk_q[0][7] |=> !irq)
      else $error("irq raised with master enable off");
   a_main_reserved: assert property (s_rd(8'h00) |-> !prdata[7] && prdata[4:3] == 2'h0)
      else $error("main event reserved bits not zero");
   a_tx_ep0_zero: assert property (s_rd(8'h10) |-> !prdata[4])
      else $error("endpoint 0 underflow bit set");
   a_mask_readback: assert property (msk_sel && !pwrite |-> prdata[7:0] == msk_q[paddr[4:3]])
      else $error("mask read differs from written value");
   a_lock_irq: assert property ($changed(sie.frame_unlocked_status) && clk_en && $past(clk_en)
      ##1 s_arm(5) |=> irq)
      else $error("lock change gave no irq");
   a_tx_irq: assert property (sie.tx_done_set[2] && clk_en ##1 s_arm(2) && msk_q[2][2] |=> irq)
      else $error("transmit done gave no irq");
   a_rx_irq: assert property (sie.rx_last_set[1] && clk_en ##1 s_arm(6) && msk_q[3][1] |=> irq)
      else $error("receive last gave no irq");
   a_irq_cause: assert property ($rose(irq) |-> $past(msk_q[0][7]))
      else $error("irq rose without master enable");
endmodule
bind unemt_event_tree unemt_event_tree_props #(.SD3_COUNT(SD3_COUNT), .SD5_COUNT(SD5_COUNT)) u_props (
   .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .sie(sie), .node_state_field(node_state_field), .irq(irq));

// ===== verif/unemt_sie_model.sv
// Serial engine and endpoint status source that faces the event tree.
`timescale 1ns/1ps
module unemt_sie_model (
   // Clock.
   input wire logic pclk,
   // Status toward the event tree.
   output unemt_pkg::unemt_sie_t sie
);
   unemt_pkg::unemt_sie_t lv;
   initial begin
      lv = '0;
      // The frame timer comes out of reset unlocked.
      lv.frame_unlocked_status = 1'b1;
      sie = lv;
   end
   // Line levels move just after an edge and stay until changed again.
   task level(input logic unl, input logic idle, input logic se0);
      lv.frame_unlocked_status = unl;
      lv.line_idle = idle;
      lv.line_se0 = se0;
      sie <= lv;
      @(posedge pclk);
   endtask
   // Strobes last one cycle; a longer strobe would count as repeated events.
   task pulse(input unemt_pkg::unemt_sie_t p);
      sie <= lv | p;
      @(posedge pclk);
      sie <= lv;
      @(posedge pclk);
   endtask
endmodule

// ===== verif/test_usb_node_event_mask_tree.sv
// Self-checking bench for the node event and mask tree.
`timescale 1ns/1ps
module test_usb_node_event_mask_tree;
   logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [7:0] paddr, q;
   logic [31:0] pwdata, prdata;
   logic [1:0] node_state_field;
   unemt_pkg::unemt_sie_t sie, p;
   int errors, checked;
   unemt_event_tree #(.SD3_COUNT(30), .SD5_COUNT(50)) dut (
      .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sie(sie), .node_state_field(node_state_field), .irq(irq));
   unemt_sie_model far (.pclk(pclk), .sie(sie));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   task wrap_up();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request stays put until pready is seen high.
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         wrap_up();
      end
      @(posedge pclk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 8'h00);
      chk(q, x);
   endtask
   // The note fixes irq at one cycle after its cause, so three cycles is ample.
   task irq_is(input logic x);
      repeat (3) @(posedge pclk);
      chk({7'h0, irq}, {7'h0, x});
   endtask
   task fire();
      p = '0;
      p.tx_done_set = 4'hf;
      p.tx_underflow_set = 4'hf;
      p.rx_last_set = 4'h2;
      p.rx_err_set = 4'h5;
      p.rx_overflow_set = 4'h1;
      far.pulse(p);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, errors, checked} = '0;
      clk_en = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
         rd(8'(4 * i), 8'h00);
      end
      apb(1'b0, 8'h24, 8'h00);
      chk({7'h0, e}, 8'h01);
      $display("test reset done");
      apb(1'b1, 8'h04, 8'h66);
      apb(1'b1, 8'h0c, 8'hff);
      apb(1'b1, 8'h14, 8'hff);
      apb(1'b1, 8'h1c, 8'hff);
      rd(8'h0c, 8'hf8);
      rd(8'h14, 8'hff);
      fire();
      far.level(1'b0, 1'b0, 1'b0);
      rd(8'h00, 8'h64);
      rd(8'h00, 8'h44);
      irq_is(1'b0);
      apb(1'b1, 8'h04, 8'he6);
      irq_is(1'b1);
      fire();
      far.level(1'b1, 1'b0, 1'b0);
      rd(8'h10, 8'hef);
      rd(8'h18, 8'h16);
      rd(8'h18, 8'h06);
      p = '0;
      p.tx_status_read = 4'hf;
      p.rx_status_read = 4'hf;
      far.pulse(p);
      rd(8'h10, 8'h00);
      rd(8'h18, 8'h00);
      rd(8'h00, 8'h20);
      irq_is(1'b0);
      $display("test events done");
      far.level(1'b1, 1'b0, 1'b1);
      repeat (626) @(posedge pclk);
      far.level(1'b1, 1'b1, 1'b0);
      repeat (52) @(posedge pclk);
      far.level(1'b1, 1'b0, 1'b0);
      p = '0;
      p.resume_seen = 1'b1;
      p.eop_seen = 1'b1;
      far.pulse(p);
      rd(8'h00, 8'h02);
      rd(8'h08, 8'h78);
      rd(8'h08, 8'h00);
      rd(8'h00, 8'h00);
      apb(1'b1, 8'h20, 8'h03);
      chk({6'h00, node_state_field}, 8'h03);
      far.pulse(p);
      rd(8'h08, 8'h88);
      apb(1'b1, 8'h20, 8'h00);
      rd(8'h20, 8'h00);
      chk({6'h00, node_state_field}, 8'h00);
      $display("test bus done");
      wrap_up();
   end
endmodule
